// >>> inc/rlc_pkg.sv
// Constants and types for the receive loopback code status and interrupt block.
// Assumes one 40 MHz clock and an APB master with 32-bit data.
package rlc_pkg;

   // ==========================================================
   // Bus geometry
   localparam int RLC_ADDR_W = 12;
   localparam int RLC_DATA_W = 32;

   // ==========================================================
   // Register indices; the byte address is four times the index
   localparam logic [7:0] RLC_IDX_STATUS = 8'h14;
   localparam logic [7:0] RLC_IDX_IRQ_EN = 8'h15;
   localparam logic [7:0] RLC_IDX_CTRL = 8'h20;
   localparam logic [11:0] RLC_ADDR_STATUS = {2'h0, RLC_IDX_STATUS, 2'h0};
   localparam logic [11:0] RLC_ADDR_IRQ_EN = {2'h0, RLC_IDX_IRQ_EN, 2'h0};
   localparam logic [11:0] RLC_ADDR_CTRL = {2'h0, RLC_IDX_CTRL, 2'h0};

   // ==========================================================
   // Field positions
   localparam int RLC_ACT_STATE_BIT = 3;
   localparam int RLC_DEACT_STATE_BIT = 2;
   localparam int RLC_ACT_EVT_BIT = 1;
   localparam int RLC_DEACT_EVT_BIT = 0;
   localparam int RLC_ACT_EN_BIT = 1;
   localparam int RLC_DEACT_EN_BIT = 0;
   localparam int RLC_ACT_DET_BIT = 1;
   localparam int RLC_DEACT_DET_BIT = 0;

   // ==========================================================
   // Reset values and writable masks
   localparam logic [1:0] RLC_EVT_RST = 2'h0;
   localparam logic [7:0] RLC_IRQ_EN_RST = 8'h00;
   localparam logic [7:0] RLC_CTRL_RST = 8'h03;
   localparam logic [7:0] RLC_WR_MASK = 8'h03;

   // ==========================================================
   // Bus handshake states
   typedef enum logic {
      RLC_APB_IDLE = 1'b0,
      RLC_APB_DONE = 1'b1
   } rlc_apb_state_t;

endpackage

// >>> inc/rlc_reg_if.sv
// Register access path between the bus port and the register file.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface rlc_reg_if #(
   parameter int ADDR_W = 12
);
   logic [ADDR_W-1:0] addr;
   logic [7:0] wdata;
   logic wr_stb;
   logic rd_stb;
   logic [7:0] rd_data;
   logic rd_hit;
   logic [7:0] snap;

   modport port (
      output addr,
      output wdata,
      output wr_stb,
      output rd_stb,
      output snap,
      input rd_data,
      input rd_hit
   );

   modport regs (
      input addr,
      input wdata,
      input wr_stb,
      input rd_stb,
      input snap,
      output rd_data,
      output rd_hit
   );
endinterface

// >>> verilog/rlc_code_track.sv
// Tracks one loopback code detector: current state and change pulse.
// Assumes the detector output is synchronous to sys_clk.
`timescale 1ns/1ps
module rlc_code_track
   import rlc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic det_en,
   input wire logic detect,
   input wire logic irq_en,
   output logic code_state,
   output logic change
);

   logic state_reg;
   logic state_next;
   logic change_reg;
   logic change_next;

   // ==========================================================
   // Next state
   always_comb begin
      // Disabling detection reads as no detection, which is a change too.
      state_next = det_en & detect;
      change_next = irq_en & (state_next != state_reg);
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state_reg <= 1'b0;
         change_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         change_reg <= change_next;
      end
   end

   assign code_state = state_reg;
   assign change = change_reg;

endmodule

// >>> verilog/rlc_apb_port.sv
// APB slave front end with one wait state and registered answers.
// Assumes a well-behaved APB master on sys_clk.
`timescale 1ns/1ps
module rlc_apb_port
   import rlc_pkg::*;
#(
   parameter int ADDR_W = RLC_ADDR_W,
   parameter int DATA_W = RLC_DATA_W
)(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   output logic pready,
   output logic [DATA_W-1:0] prdata,
   output logic pslverr,
   rlc_reg_if.port rif
);

   rlc_apb_state_t state_reg;
   rlc_apb_state_t state_next;
   logic [DATA_W-1:0] prdata_reg;
   logic [DATA_W-1:0] prdata_next;
   logic pslverr_reg;
   logic pslverr_next;

   // ==========================================================
   // Handshake
   always_comb begin
      state_next = state_reg;
      prdata_next = prdata_reg;
      pslverr_next = pslverr_reg;
      case (state_reg)
         RLC_APB_IDLE: begin
            if (psel && penable) begin
               state_next = RLC_APB_DONE;
               prdata_next = {{(DATA_W-8){1'b0}}, rif.rd_data};
               pslverr_next = ~rif.rd_hit;
            end
         end
         default: begin
            state_next = RLC_APB_IDLE;
            pslverr_next = 1'b0;
         end
      endcase
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state_reg <= RLC_APB_IDLE;
         prdata_reg <= '0;
         pslverr_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         prdata_reg <= prdata_next;
         pslverr_reg <= pslverr_next;
      end
   end

   // Effects land on the completing edge, as the master sees them.
   assign pready = (state_reg == RLC_APB_DONE);
   assign prdata = prdata_reg;
   assign pslverr = pslverr_reg;
   assign rif.addr = paddr;
   assign rif.wdata = pwdata[7:0];
   assign rif.wr_stb = psel & penable & pready & pwrite;
   assign rif.rd_stb = psel & penable & pready & ~pwrite;
   assign rif.snap = prdata_reg[7:0];

endmodule

// >>> verilog/rlc_irq_status.sv
// Receive loopback code status, change events and interrupt request.
// Assumes synchronous level inputs from the two code detectors and an
// APB master on the same 40 MHz clock.
//
// Operation
// - Activation state bit follows enabled activation detection
// - Deactivation state bit follows enabled deactivation detection
// - Activation change sets event; status read clears
// - Deactivation change sets event; status read clears
// - Enable bit 1 gates activation change
// - Enable bit 0 gates deactivation; 7-2 reserved
//
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ps
module rlc_irq_status
   import rlc_pkg::*;
#(
   parameter int ADDR_W = RLC_ADDR_W,
   parameter int DATA_W = RLC_DATA_W
)(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   output logic pready,
   output logic [DATA_W-1:0] prdata,
   output logic pslverr,
   input wire logic act_code_detect,
   input wire logic deact_code_detect,
   output logic irq
);

   // ==========================================================
   // Declarations
   rlc_reg_if #(.ADDR_W(ADDR_W)) rif ();

   logic [1:0] evt_reg;
   logic [1:0] evt_next;
   logic [7:0] irq_en_reg;
   logic [7:0] irq_en_next;
   logic [7:0] ctrl_reg;
   logic [7:0] ctrl_next;
   logic irq_reg;
   logic irq_next;
   logic act_code_state;
   logic deact_code_state;
   logic act_chg;
   logic deact_chg;
   logic [1:0] evt_clr;
   logic [1:0] evt_set;
   logic hit_status;
   logic hit_irq_en;
   logic hit_ctrl;

   // ==========================================================
   // Bus port
   rlc_apb_port #(
      .ADDR_W(ADDR_W),
      .DATA_W(DATA_W)
   ) u_port (
      .sys_clk(sys_clk),
      .reset(reset),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .pready(pready),
      .prdata(prdata),
      .pslverr(pslverr),
      .rif(rif.port)
   );

   // ==========================================================
   // Code trackers
   rlc_code_track u_act (
      .sys_clk(sys_clk),
      .reset(reset),
      .det_en(ctrl_reg[RLC_ACT_DET_BIT]),
      .detect(act_code_detect),
      .irq_en(irq_en_reg[RLC_ACT_EN_BIT]),
      .code_state(act_code_state),
      .change(act_chg)
   );

   rlc_code_track u_deact (
      .sys_clk(sys_clk),
      .reset(reset),
      .det_en(ctrl_reg[RLC_DEACT_DET_BIT]),
      .detect(deact_code_detect),
      .irq_en(irq_en_reg[RLC_DEACT_EN_BIT]),
      .code_state(deact_code_state),
      .change(deact_chg)
   );

   // ==========================================================
   // Address decode and read data
   always_comb begin
      hit_status = 1'b0;
      hit_irq_en = 1'b0;
      hit_ctrl = 1'b0;
      rif.rd_data = 8'h00;
      rif.rd_hit = 1'b1;
      if (rif.addr == ADDR_W'(RLC_ADDR_STATUS)) begin
         hit_status = 1'b1;
         rif.rd_data[RLC_ACT_STATE_BIT] = act_code_state;
         rif.rd_data[RLC_DEACT_STATE_BIT] = deact_code_state;
         rif.rd_data[RLC_ACT_EVT_BIT] = evt_reg[RLC_ACT_EVT_BIT];
         rif.rd_data[RLC_DEACT_EVT_BIT] = evt_reg[RLC_DEACT_EVT_BIT];
      end else if (rif.addr == ADDR_W'(RLC_ADDR_IRQ_EN)) begin
         hit_irq_en = 1'b1;
         rif.rd_data = irq_en_reg;
      end else if (rif.addr == ADDR_W'(RLC_ADDR_CTRL)) begin
         hit_ctrl = 1'b1;
         rif.rd_data = ctrl_reg;
      end else begin
         rif.rd_hit = 1'b0;
      end
   end

   // ==========================================================
   // Register file next values
   always_comb begin
      irq_en_next = irq_en_reg;
      ctrl_next = ctrl_reg;
      evt_clr = 2'h0;
      evt_set = 2'h0;
      if (rif.wr_stb && hit_irq_en) begin
         irq_en_next = rif.wdata & RLC_WR_MASK;
      end
      if (rif.wr_stb && hit_ctrl) begin
         ctrl_next = rif.wdata & RLC_WR_MASK;
      end
      // Only bits that were actually returned are cleared, so an event
      // landing between capture and completion is never lost.
      if (rif.rd_stb && hit_status) begin
         evt_clr[RLC_ACT_EVT_BIT] = rif.snap[RLC_ACT_EVT_BIT];
         evt_clr[RLC_DEACT_EVT_BIT] = rif.snap[RLC_DEACT_EVT_BIT];
      end
      evt_set[RLC_ACT_EVT_BIT] = act_chg;
      evt_set[RLC_DEACT_EVT_BIT] = deact_chg;
      // A new event wins over a clear in the same cycle.
      evt_next = (evt_reg & ~evt_clr) | evt_set;
      // Built from next values so the output is a flop yet agrees with the
      // registers in the very cycle that they change.
      irq_next = |(evt_next & irq_en_next[1:0]);
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         evt_reg <= RLC_EVT_RST;
         irq_en_reg <= RLC_IRQ_EN_RST;
         ctrl_reg <= RLC_CTRL_RST;
         irq_reg <= 1'b0;
      end else begin
         evt_reg <= evt_next;
         irq_en_reg <= irq_en_next;
         ctrl_reg <= ctrl_next;
         irq_reg <= irq_next;
      end
   end

   assign irq = irq_reg;

   // ==========================================================
   // Assertions
   // They are off during reset; the first $past after release sees reset
   // values, which match the idle level of every input.
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   sequence s_access_start;
      psel && penable && !pready;
   endsequence

   sequence s_answer;
      ##1 pready;
   endsequence

   sequence s_status_read;
      rif.rd_stb && hit_status;
   endsequence

   sequence s_en_write;
      rif.wr_stb && hit_irq_en;
   endsequence

   sequence s_status_write;
      rif.wr_stb && hit_status;
   endsequence

   sequence s_ctrl_write;
      rif.wr_stb && hit_ctrl;
   endsequence

   a_apb_one_wait: assert property (
      s_access_start |-> s_answer ##1 !pready
   ) else $error("APB answer not after exactly one wait cycle");

   a_apb_unmapped_err: assert property (
      s_access_start ##0 !rif.rd_hit |=> pready && pslverr
   ) else $error("Unmapped access did not raise pslverr");

   a_act_state_track: assert property (
      1'b1 |=> act_code_state == $past(ctrl_reg[RLC_ACT_DET_BIT] & act_code_detect)
   ) else $error("Activation state does not follow detection");

   a_deact_state_track: assert property (
      1'b1 |=> deact_code_state ==
         $past(ctrl_reg[RLC_DEACT_DET_BIT] & deact_code_detect)
   ) else $error("Deactivation state does not follow detection");

   a_state_read_back: assert property (
      s_access_start ##0 hit_status |=>
         prdata[RLC_ACT_STATE_BIT] == $past(act_code_state) &&
         prdata[RLC_DEACT_STATE_BIT] == $past(deact_code_state)
   ) else $error("Status read returned wrong state bits");

   a_act_evt_set: assert property (
      $changed(act_code_state) && $past(irq_en_reg[RLC_ACT_EN_BIT])
         |=> evt_reg[RLC_ACT_EVT_BIT]
   ) else $error("Activation change did not set its event");

   a_act_evt_gated: assert property (
      !$past(irq_en_reg[RLC_ACT_EN_BIT]) && !evt_reg[RLC_ACT_EVT_BIT] ##1
         !$past(irq_en_reg[RLC_ACT_EN_BIT]) |-> !evt_reg[RLC_ACT_EVT_BIT]
   ) else $error("Activation event set while disabled");

   a_deact_evt_set: assert property (
      $changed(deact_code_state) && $past(irq_en_reg[RLC_DEACT_EN_BIT])
         |=> evt_reg[RLC_DEACT_EVT_BIT]
   ) else $error("Deactivation change did not set its event");

   a_evt_read_clear: assert property (
      s_status_read ##0 rif.snap[RLC_ACT_EVT_BIT] && !act_chg
         |=> !evt_reg[RLC_ACT_EVT_BIT]
   ) else $error("Status read did not clear activation event");

   a_deact_read_clear: assert property (
      s_status_read ##0 rif.snap[RLC_DEACT_EVT_BIT] && !deact_chg
         |=> !evt_reg[RLC_DEACT_EVT_BIT]
   ) else $error("Status read did not clear deactivation event");

   a_evt_set_wins: assert property (
      s_status_read ##0 act_chg |=> evt_reg[RLC_ACT_EVT_BIT]
   ) else $error("Event lost against a clearing read");

   a_en_write_store: assert property (
      s_en_write |=> irq_en_reg == ($past(rif.wdata) & RLC_WR_MASK)
   ) else $error("Enable register write not stored");

   a_en_reserved_zero: assert property (
      irq_en_reg[7:2] == 6'h00
   ) else $error("Reserved enable bits not zero");

   a_irq_level: assert property (
      1'b1 |=> irq == |(evt_reg & irq_en_reg[1:0])
   ) else $error("Interrupt output disagrees with enabled events");

   a_irq_drops_read: assert property (
      s_status_read ##0 (rif.snap[1:0] == evt_reg) && !act_chg && !deact_chg
         |=> !irq
   ) else $error("Interrupt stayed high after clearing read");

   a_deact_evt_gated: assert property (
      !$past(irq_en_reg[RLC_DEACT_EN_BIT]) && !evt_reg[RLC_DEACT_EVT_BIT] ##1
         !$past(irq_en_reg[RLC_DEACT_EN_BIT]) |-> !evt_reg[RLC_DEACT_EVT_BIT]
   ) else $error("Deactivation event set while disabled");

   a_deact_set_wins: assert property (
      s_status_read ##0 deact_chg |=> evt_reg[RLC_DEACT_EVT_BIT]
   ) else $error("Deactivation event lost against a clearing read");

   a_act_det_off: assert property (
      !ctrl_reg[RLC_ACT_DET_BIT] |=> !act_code_state
   ) else $error("Activation state set with detection off");

   a_deact_det_off: assert property (
      !ctrl_reg[RLC_DEACT_DET_BIT] |=> !deact_code_state
   ) else $error("Deactivation state set with detection off");

   a_en_read_back: assert property (
      s_access_start ##0 hit_irq_en |=> prdata[7:0] == $past(irq_en_reg)
   ) else $error("Enable register read returned wrong value");

   // A write to the status register must never act as a clear; only a read may.
   a_status_wr_ignored: assert property (
      s_status_write ##0 !act_chg && !deact_chg |=> evt_reg == $past(evt_reg)
   ) else $error("Status write changed the event bits");

   a_ctrl_write_store: assert property (
      s_ctrl_write |=> ctrl_reg == ($past(rif.wdata) & RLC_WR_MASK)
   ) else $error("Control register write not stored");

   a_ready_one_cycle: assert property (
      pready |=> !pready
   ) else $error("APB ready held longer than one cycle");

   a_read_upper_zero: assert property (
      pready |-> prdata[DATA_W-1:8] == '0
   ) else $error("Upper read data bits not zero");

endmodule

// >>> sim/rlc_code_source.sv
// Behavioural far end: remote equipment sending in-band loopback codes.
// Assumes the detector levels it yields are registered on sys_clk.
`timescale 1ns/1ps
module rlc_code_source
   import rlc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic send_act,
   input wire logic send_deact,
   output logic act_code_detect,
   output logic deact_code_detect
);
   // ==========================================================
   // Code levels
   // A code stays seen for as long as the remote end sends it; a detector
   // cannot see anything while the device sits in reset.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         act_code_detect <= 1'h0;
         deact_code_detect <= 1'h0;
      end else begin
         act_code_detect <= send_act;
         deact_code_detect <= send_deact;
      end
   end
endmodule

// >>> sim/test_rx_loop_code_irq_status.sv
// Self-checking bench for the loopback code status and interrupt block.
// Assumes one APB wait state and events flagged two edges after a code change.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
   $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module test_rx_loop_code_irq_status
   import rlc_pkg::*;
;
   // ==========================================================
   // Signals
   typedef struct packed {
      logic [7:0] en;
      logic a;
      logic d;
      logic [7:0] on;
      logic [7:0] off;
   } rlc_row_t;
   logic sys_clk = 1'h0;
   logic reset = 1'h1;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   logic act_det;
   logic deact_det;
   logic send_act = 1'h0;
   logic send_deact = 1'h0;
   int n_errors = 0;
   int checks = 0;
   int cyc = 0;
   // Status seen while the codes stand, then after they stop.
   rlc_row_t rows [7] = '{
      '{8'h03, 1'h1, 1'h0, 8'h0a, 8'h02}, '{8'h03, 1'h0, 1'h1, 8'h05, 8'h01},
      '{8'h03, 1'h1, 1'h1, 8'h0f, 8'h03}, '{8'h00, 1'h1, 1'h1, 8'h0c, 8'h00},
      '{8'h02, 1'h1, 1'h1, 8'h0e, 8'h02}, '{8'h01, 1'h1, 1'h1, 8'h0d, 8'h01},
      '{8'hfc, 1'h1, 1'h1, 8'h0c, 8'h00}};

   // ==========================================================
   // Instances
   rlc_irq_status u_dut (
      .sys_clk(sys_clk),
      .reset(reset),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .pready(pready),
      .prdata(prdata),
      .pslverr(pslverr),
      .act_code_detect(act_det),
      .deact_code_detect(deact_det),
      .irq(irq)
   );
   rlc_code_source u_far (
      .sys_clk(sys_clk),
      .reset(reset),
      .send_act(send_act),
      .send_deact(send_deact),
      .act_code_detect(act_det),
      .deact_code_detect(deact_det)
   );

   initial begin
      forever #12.5 sys_clk = ~sys_clk;
   end

   // ==========================================================
   // Tasks
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Called just after a rising edge; the request is held until pready.
   // One idle edge follows, so a next call never drives psel twice in a step.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge sys_clk);
      penable <= 1'h1;
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge sys_clk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(1'h1, a, {24'h0, d}, r, e);
   endtask

   task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] x,
                         input logic xe);
      logic [31:0] r;
      logic e;
      apb(1'h0, a, 32'h0, r, e);
      `CHK(nm, x, r)
      `CHK("pslverr", xe, e)
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   task automatic codes(input logic a, input logic d);
      send_act <= a;
      send_deact <= d;
   endtask

   // Ceiling sits far above the few hundred cycles the tests need.
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_errors++;
         end_sim();
      end
   end

   // ==========================================================
   // Tests
   initial begin
      wt(4);
      reset <= 1'h0;
      wt(1);
      `CHK("irq", 1'h0, irq)
      rd_chk("status", RLC_ADDR_STATUS, 32'h0, 1'h0);
      rd_chk("enable", RLC_ADDR_IRQ_EN, 32'h0, 1'h0);
      rd_chk("control", RLC_ADDR_CTRL, 32'h3, 1'h0);
      $display("test reset done");
      foreach (rows[i]) begin
         wr(RLC_ADDR_IRQ_EN, rows[i].en);
         codes(rows[i].a, rows[i].d);
         wt(4);
         `CHK("irq", |rows[i].on[1:0], irq)
         rd_chk("status on", RLC_ADDR_STATUS, {24'h0, rows[i].on}, 1'h0);
         wt(1);
         `CHK("irq cleared", 1'h0, irq)
         codes(1'h0, 1'h0);
         wt(4);
         rd_chk("status off", RLC_ADDR_STATUS, {24'h0, rows[i].off}, 1'h0);
         rd_chk("enable", RLC_ADDR_IRQ_EN, {24'h0, rows[i].en & 8'h03}, 1'h0);
      end
      $display("test table done");
      wr(RLC_ADDR_IRQ_EN, 8'h02);
      codes(1'h1, 1'h0);
      wt(4);
      wr(RLC_ADDR_IRQ_EN, 8'h00);
      wt(1);
      `CHK("irq masked", 1'h0, irq)
      wr(RLC_ADDR_IRQ_EN, 8'h02);
      wt(1);
      `CHK("irq unmasked", 1'h1, irq)
      rd_chk("sticky", RLC_ADDR_STATUS, 32'h0a, 1'h0);
      codes(1'h0, 1'h0);
      wt(4);
      rd_chk("end event", RLC_ADDR_STATUS, 32'h02, 1'h0);
      $display("test mask done");
      rd_chk("unmapped", 12'h0fc, 32'h0, 1'h1);
      wr(RLC_ADDR_STATUS, 8'hff);
      rd_chk("status ro", RLC_ADDR_STATUS, 32'h0, 1'h0);
      $display("test refusal done");
      wr(RLC_ADDR_IRQ_EN, 8'h03);
      wr(RLC_ADDR_CTRL, 8'h00);
      codes(1'h1, 1'h1);
      wt(4);
      rd_chk("det off", RLC_ADDR_STATUS, 32'h0, 1'h0);
      `CHK("irq det off", 1'h0, irq)
      wr(RLC_ADDR_CTRL, 8'h03);
      wt(4);
      rd_chk("det on", RLC_ADDR_STATUS, 32'h0f, 1'h0);
      codes(1'h0, 1'h0);
      wt(4);
      rd_chk("det gone", RLC_ADDR_STATUS, 32'h03, 1'h0);
      $display("test detection done");
      wr(RLC_ADDR_IRQ_EN, 8'h03);
      codes(1'h1, 1'h1);
      wt(4);
      `CHK("irq pre reset", 1'h1, irq)
      reset <= 1'h1;
      codes(1'h0, 1'h0);
      wt(2);
      `CHK("irq in reset", 1'h0, irq)
      reset <= 1'h0;
      wt(1);
      rd_chk("status reset", RLC_ADDR_STATUS, 32'h0, 1'h0);
      rd_chk("enable reset", RLC_ADDR_IRQ_EN, 32'h0, 1'h0);
      rd_chk("control reset", RLC_ADDR_CTRL, 32'h3, 1'h0);
      $display("test mid reset done");
      end_sim();
   end
endmodule
